// file: inc/mase_defines.svh
`ifndef MASE_DEFINES_SVH
`define MASE_DEFINES_SVH
`define MASE_DATA_W 8
`define MASE_PROG_W 15
`define MASE_PC_W 12
`define MASE_ADDR_W 8
`define MASE_FILL_ONES 8'hFF
`define MASE_ONE 8'h01
`define MASE_ZERO 8'h00
`define MASE_FLAG_RESET 4'h0
`define MASE_FLAG_C 0
`define MASE_FLAG_AC 1
`define MASE_FLAG_Z 2
`define MASE_FLAG_OV 3
`endif

// file: inc/mase_pkg.sv
package mase_pkg;
    typedef enum logic [3:0] {
        MASE_OP_NONE = 4'h0,
        MASE_OP_FILL = 4'h1,
        MASE_OP_BITSET = 4'h2,
        MASE_OP_INC_SKIP = 4'h3,
        MASE_OP_INC_SKIP_A = 4'h4,
        MASE_OP_SKIP_BIT_HIGH = 4'h5,
        MASE_OP_SUB_A = 4'h6,
        MASE_OP_SUB_M = 4'h7,
        MASE_OP_SUB_X = 4'h8,
        MASE_OP_SWAP = 4'h9,
        MASE_OP_SWAP_A = 4'hA,
        MASE_OP_SKIP_ZERO = 4'hB,
        MASE_OP_COPY_SKIP = 4'hC,
        MASE_OP_SKIP_BIT_LOW = 4'hD,
        MASE_OP_TAB_CUR = 4'hE,
        MASE_OP_TAB_LAST = 4'hF
    } mase_op_t;

    typedef enum logic [1:0] {
        MASE_XOP_NONE = 2'h0,
        MASE_XOP_XOR_A = 2'h1,
        MASE_XOP_XOR_M = 2'h2,
        MASE_XOP_XOR_X = 2'h3
    } mase_xop_t;

    typedef struct packed {
        logic valid;
        mase_op_t op;
        mase_xop_t xop;
        logic [2:0] bit_sel;
        logic [7:0] mem_addr;
        logic [7:0] mem_data;
        logic [7:0] literal;
    } mase_req_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } mase_flags_t;

    typedef enum logic [1:0] {
        MASE_ST_RUN = 2'b01,
        MASE_ST_WAIT = 2'b10
    } mase_state_t;
endpackage : mase_pkg

// file: hw/mase_sub.sv
`timescale 1ns/1ps
`default_nettype none
// 8-bit subtract with carry-as-not-borrow flags
module mase_sub (
    input wire logic [7:0] a_in, // Minuend
    input wire logic [7:0] b_in, // Subtrahend
    output logic [7:0] diff_out, // Difference
    output logic ov_out, // Signed overflow
    output logic ac_out, // Low nibble no-borrow
    output logic c_out // No-borrow
);
    logic [8:0] full;
    logic [4:0] low;
    assign full = {1'b0, a_in} - {1'b0, b_in};
    assign low = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]};
    assign diff_out = full[7:0];
    assign c_out = ~full[8];
    assign ac_out = ~low[4];
    assign ov_out = (a_in[7] ^ b_in[7]) & (a_in[7] ^ full[7]);
endmodule : mase_sub
`default_nettype wire

// file: hw/mase_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "mase_defines.svh"
// What this block does
// RQ1: Fill-ones writes 8'hFF, flags untouched.
// RQ2: Bit-set forces selected bit only.
// RQ3: Increment memory, write back, skip on zero.
// RQ4: Increment into accumulator only, skip on zero.
// RQ5: Skip when selected bit is one.
// RQ6: Skip-type instructions take two cycles.
// RQ7: Subtract memory into accumulator, four flags.
// RQ8: Subtract, result to memory, four flags.
// RQ9: Subtract literal into accumulator, four flags.
// RQ10: Carry is not-borrow for subtraction.
// RQ11: Nibble swap in memory, no flags.
// RQ12: Nibble swap into accumulator, memory kept.
// RQ13: Skip when memory byte is zero.
// RQ14: Copy to accumulator, skip on zero.
// RQ15: Skip when selected bit is zero.
// RQ16: Current-page table fetch to memory, high register.
// RQ17: Final-page table fetch, same as current.
// RQ18: XOR into accumulator, zero flag only.
// RQ19: XOR into memory, zero flag only.
// RQ20: XOR literal into accumulator, zero flag only.
// RQ21: Non-skipping instructions other than table fetches finish in one cycle.
module mase_exec
    import mase_pkg::*;
#(
    parameter int PC_W = `MASE_PC_W,
    parameter int PROG_W = `MASE_PROG_W
) (
    input wire logic sys_clk_in, // System clock
    input wire logic rst_in, // Async reset, high
    input wire mase_req_t req_in, // Decoded instruction
    input wire logic [PC_W-1:0] pc_in, // Current program counter
    input wire logic [7:0] table_index_pointer_in, // Table pointer
    input wire logic [PROG_W-1:0] prog_data_in, // Program memory word
    output logic [PC_W-1:0] prog_addr_out, // Program memory address
    output logic prog_rd_out, // Program memory read pulse
    output logic mem_we_out, // Data memory write pulse
    output logic [7:0] mem_addr_out, // Data memory address
    output logic [7:0] mem_wdata_out, // Data memory write data
    output logic [7:0] acc_out, // Accumulator
    output var mase_flags_t flags_out, // Status flags
    output logic [PROG_W-9:0] table_read_high_reg_out, // Table high
    output logic skip_out, // Skip next instruction pulse
    output logic busy_out // Second cycle in progress
);
    mase_state_t state_q;
    logic [7:0] acc_q;
    mase_flags_t flags_q;
    logic [PROG_W-9:0] table_read_high_reg_q;
    logic we_q;
    logic [7:0] waddr_q;
    logic [7:0] wdata_q;
    logic skip_q;
    logic [PC_W-1:0] paddr_q;
    logic prd_q;
    logic [7:0] tab_addr_q;
    logic [7:0] sub_b;
    logic [7:0] sub_d;
    logic sub_ov;
    logic sub_ac;
    logic sub_c;
    logic [7:0] m;
    logic [7:0] inc_v;
    logic [7:0] xor_v;
    logic bit_v;
    logic go;

    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        swap_nib = {v[3:0], v[7:4]};
    endfunction : swap_nib

    function automatic logic is_skip_op(input mase_op_t op);
        is_skip_op = (op == MASE_OP_INC_SKIP) || (op == MASE_OP_INC_SKIP_A)
            || (op == MASE_OP_SKIP_BIT_HIGH) || (op == MASE_OP_SKIP_ZERO)
            || (op == MASE_OP_COPY_SKIP) || (op == MASE_OP_SKIP_BIT_LOW);
    endfunction : is_skip_op

    assign m = req_in.mem_data;
    assign go = req_in.valid && (state_q == MASE_ST_RUN);
    assign inc_v = m + `MASE_ONE;
    assign xor_v = acc_q ^ (req_in.xop == MASE_XOP_XOR_X ? req_in.literal : m);
    assign bit_v = m[req_in.bit_sel];
    assign sub_b = (req_in.op == MASE_OP_SUB_X) ? req_in.literal : m;

    mase_sub u_sub (
        .a_in(acc_q),
        .b_in(sub_b),
        .diff_out(sub_d),
        .ov_out(sub_ov),
        .ac_out(sub_ac),
        .c_out(sub_c)
    );

    // Two-cycle sequencing for skips and table fetches
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= MASE_ST_RUN;
        end else begin
            case (state_q)
                MASE_ST_RUN: begin
                    if (go && req_in.xop == MASE_XOP_NONE
                        && (is_skip_op(req_in.op)
                        || req_in.op == MASE_OP_TAB_CUR
                        || req_in.op == MASE_OP_TAB_LAST)) begin
                        state_q <= MASE_ST_WAIT; // RQ6
                    end
                end
                MASE_ST_WAIT: state_q <= MASE_ST_RUN;
                default: state_q <= MASE_ST_RUN;
            endcase
        end
    end

    // Skip decision
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= 1'b0;
            if (go && req_in.xop == MASE_XOP_NONE) begin
                case (req_in.op)
                    MASE_OP_INC_SKIP: skip_q <= (inc_v == `MASE_ZERO); // RQ3
                    MASE_OP_INC_SKIP_A: skip_q <= (inc_v == `MASE_ZERO); // RQ4
                    MASE_OP_SKIP_BIT_HIGH: skip_q <= bit_v; // RQ5
                    MASE_OP_SKIP_ZERO: skip_q <= (m == `MASE_ZERO); // RQ13
                    MASE_OP_COPY_SKIP: skip_q <= (m == `MASE_ZERO); // RQ14
                    MASE_OP_SKIP_BIT_LOW: skip_q <= ~bit_v; // RQ15
                    default: skip_q <= 1'b0;
                endcase
            end
        end
    end

    // Accumulator
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_q <= `MASE_ZERO;
        end else if (go && req_in.xop != MASE_XOP_NONE) begin
            if (req_in.xop != MASE_XOP_XOR_M) begin
                acc_q <= xor_v; // RQ18 RQ20
            end
        end else if (go) begin
            case (req_in.op)
                MASE_OP_INC_SKIP_A: acc_q <= inc_v; // RQ4
                MASE_OP_SUB_A: acc_q <= sub_d; // RQ7
                MASE_OP_SUB_X: acc_q <= sub_d; // RQ9
                MASE_OP_SWAP_A: acc_q <= swap_nib(m); // RQ12
                MASE_OP_COPY_SKIP: acc_q <= m; // RQ14
                default: acc_q <= acc_q;
            endcase
        end
    end

    // Status flags
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_q <= `MASE_FLAG_RESET;
        end else if (go && req_in.xop != MASE_XOP_NONE) begin
            flags_q.z <= (xor_v == `MASE_ZERO); // RQ18 RQ19 RQ20
        end else if (go && (req_in.op == MASE_OP_SUB_A
            || req_in.op == MASE_OP_SUB_M || req_in.op == MASE_OP_SUB_X)) begin
            flags_q.ov <= sub_ov; // RQ7 RQ8 RQ9
            flags_q.z <= (sub_d == `MASE_ZERO);
            flags_q.ac <= sub_ac;
            flags_q.c <= sub_c; // RQ10
        end
    end

    // Data memory write-back
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            we_q <= 1'b0;
            waddr_q <= `MASE_ZERO;
            wdata_q <= `MASE_ZERO;
        end else begin
            we_q <= 1'b0;
            if (state_q == MASE_ST_WAIT && prd_q) begin
                we_q <= 1'b1; // RQ16 RQ17
                waddr_q <= tab_addr_q;
                wdata_q <= prog_data_in[7:0];
            end else if (go && req_in.xop == MASE_XOP_XOR_M) begin
                we_q <= 1'b1; // RQ19
                waddr_q <= req_in.mem_addr;
                wdata_q <= xor_v;
            end else if (go && req_in.xop == MASE_XOP_NONE) begin
                waddr_q <= req_in.mem_addr;
                case (req_in.op)
                    MASE_OP_FILL: begin
                        we_q <= 1'b1; // RQ1
                        wdata_q <= `MASE_FILL_ONES;
                    end
                    MASE_OP_BITSET: begin
                        we_q <= 1'b1; // RQ2
                        wdata_q <= m | (`MASE_ONE << req_in.bit_sel);
                    end
                    MASE_OP_INC_SKIP: begin
                        we_q <= 1'b1; // RQ3
                        wdata_q <= inc_v;
                    end
                    MASE_OP_SUB_M: begin
                        we_q <= 1'b1; // RQ8
                        wdata_q <= sub_d;
                    end
                    MASE_OP_SWAP: begin
                        we_q <= 1'b1; // RQ11
                        wdata_q <= swap_nib(m);
                    end
                    default: we_q <= 1'b0;
                endcase
            end
        end
    end

    // Table fetch address and high bits
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            paddr_q <= '0;
            prd_q <= 1'b0;
            tab_addr_q <= `MASE_ZERO;
            table_read_high_reg_q <= '0;
        end else begin
            prd_q <= 1'b0;
            if (go && req_in.xop == MASE_XOP_NONE
                && req_in.op == MASE_OP_TAB_CUR) begin
                prd_q <= 1'b1; // RQ16
                paddr_q <= {pc_in[PC_W-1:8], table_index_pointer_in};
                tab_addr_q <= req_in.mem_addr;
            end else if (go && req_in.xop == MASE_XOP_NONE
                && req_in.op == MASE_OP_TAB_LAST) begin
                prd_q <= 1'b1; // RQ17
                paddr_q <= {{(PC_W-8){1'b1}}, table_index_pointer_in};
                tab_addr_q <= req_in.mem_addr;
            end
            if (state_q == MASE_ST_WAIT && prd_q) begin
                table_read_high_reg_q <= prog_data_in[PROG_W-1:8];
            end
        end
    end

    assign acc_out = acc_q;
    assign flags_out = flags_q;
    assign table_read_high_reg_out = table_read_high_reg_q;
    assign mem_we_out = we_q;
    assign mem_addr_out = waddr_q;
    assign mem_wdata_out = wdata_q;
    assign skip_out = skip_q;
    assign prog_addr_out = paddr_q;
    assign prog_rd_out = prd_q;
    // Wait bit of the one-hot state, straight from the flop
    assign busy_out = state_q[1]; // RQ6 RQ21

    sequence s_skip_issue;
        go && req_in.xop == MASE_XOP_NONE && is_skip_op(req_in.op);
    endsequence

    sequence s_dummy_slot;
        busy_out ##1 !busy_out;
    endsequence

    property p_two_cycle;
        @(posedge sys_clk_in) disable iff (rst_in)
        s_skip_issue |=> s_dummy_slot;
    endproperty
    a_two_cycle: assert property (p_two_cycle) // RQ6
        else $error("skip op not two cycles");

    property p_single;
        @(posedge sys_clk_in) disable iff (rst_in)
        go && (req_in.op == MASE_OP_SUB_A || req_in.xop != MASE_XOP_NONE)
        |=> !busy_out;
    endproperty
    a_single: assert property (p_single) // RQ21
        else $error("single-cycle op stalled");

    property p_fill;
        @(posedge sys_clk_in) disable iff (rst_in)
        go && req_in.xop == MASE_XOP_NONE && req_in.op == MASE_OP_FILL
        |=> mem_we_out && mem_wdata_out == 8'hFF && $stable(flags_out);
    endproperty
    a_fill: assert property (p_fill) // RQ1
        else $error("fill ones wrong");

    property p_inc_skip;
        @(posedge sys_clk_in) disable iff (rst_in)
        go && req_in.xop == MASE_XOP_NONE && req_in.op == MASE_OP_INC_SKIP
        |=> skip_out == (mem_wdata_out == 8'h00) && mem_we_out;
    endproperty
    a_inc_skip: assert property (p_inc_skip) // RQ3
        else $error("inc skip mismatch");

    property p_sub_carry;
        @(posedge sys_clk_in) disable iff (rst_in)
        go && req_in.xop == MASE_XOP_NONE && req_in.op == MASE_OP_SUB_A
        |=> flags_out.c == ($past(acc_q) >= $past(m)) && acc_out
            == $past(acc_q) - $past(m);
    endproperty
    a_sub_carry: assert property (p_sub_carry) // RQ10
        else $error("subtract carry wrong");

    property p_xor_flags;
        @(posedge sys_clk_in) disable iff (rst_in)
        go && req_in.xop == MASE_XOP_XOR_A
        |=> acc_out == ($past(acc_q) ^ $past(m)) && $stable(flags_out.c)
            && flags_out.z == (acc_out == 8'h00);
    endproperty
    a_xor_flags: assert property (p_xor_flags) // RQ18
        else $error("xor flags wrong");

    property p_swap_a;
        @(posedge sys_clk_in) disable iff (rst_in)
        go && req_in.xop == MASE_XOP_NONE && req_in.op == MASE_OP_SWAP_A
        |=> acc_out == {$past(m[3:0]), $past(m[7:4])} && !mem_we_out;
    endproperty
    a_swap_a: assert property (p_swap_a) // RQ12
        else $error("swap to acc wrong");

    property p_table;
        @(posedge sys_clk_in) disable iff (rst_in)
        go && req_in.xop == MASE_XOP_NONE && req_in.op == MASE_OP_TAB_LAST
        |=> prog_rd_out && prog_addr_out[7:0] == $past(table_index_pointer_in)
            && &prog_addr_out[PC_W-1:8] ##1 mem_we_out;
    endproperty
    a_table: assert property (p_table) // RQ17
        else $error("final page fetch wrong");
endmodule : mase_exec
`default_nettype wire

// file: dv/mase_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mase_pkg::*;
();
    typedef struct {
        int due;
        logic [7:0] acc;
        mase_flags_t fl;
        logic we;
        logic [7:0] wa;
        logic [7:0] wd;
        logic skip;
        logic busy;
        logic rd;
        logic [11:0] pa;
        logic [6:0] th;
    } mase_tb_note_t;

    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    mase_req_t req_in = '0;
    logic [11:0] pc_in = 12'h000;
    logic [7:0] tp_in = 8'h00;
    logic [14:0] prog_data;
    logic [11:0] prog_addr;
    logic prog_rd, mem_we, skip, busy;
    logic [7:0] mem_addr, mem_wdata, acc;
    mase_flags_t flags;
    logic [6:0] table_read_high_reg;
    mase_tb_note_t notes[$];
    int n_fail = 0;
    int tests_run = 0;
    int ncyc = 0;
    int cyc_cnt = 0;
    logic [7:0] e_acc = 8'h00;
    mase_flags_t e_fl = '0;
    logic [6:0] e_th = 7'h00;

    // Program memory answers combinationally
    function automatic logic [14:0] word(logic [11:0] a);
        return {a[6:0] ^ 7'h2A, a[7:0] ^ 8'hC3};
    endfunction : word

    assign prog_data = word(prog_addr);

    mase_exec mase_exec_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(req_in),
        .pc_in(pc_in), .table_index_pointer_in(tp_in),
        .prog_data_in(prog_data), .prog_addr_out(prog_addr),
        .prog_rd_out(prog_rd), .mem_we_out(mem_we),
        .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
        .acc_out(acc), .flags_out(flags),
        .table_read_high_reg_out(table_read_high_reg), .skip_out(skip),
        .busy_out(busy)
    );

    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    always @(posedge sys_clk_in) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin : monitor
        mase_tb_note_t n;
        forever begin
            @(negedge sys_clk_in);
            ncyc++;
            while (notes.size() > 0 && notes[0].due == ncyc) begin
                n = notes.pop_front();
                check("acc", {8'h00, acc}, {8'h00, n.acc});
                check("flags", {12'h000, flags}, {12'h000, n.fl});
                check("mem_we", {15'h0000, mem_we}, {15'h0000, n.we});
                if (n.we) begin
                    check("mem_addr", {8'h00, mem_addr}, {8'h00, n.wa});
                    check("mem_wdata", {8'h00, mem_wdata}, {8'h00, n.wd});
                end
                check("skip", {15'h0000, skip}, {15'h0000, n.skip});
                check("busy", {15'h0000, busy}, {15'h0000, n.busy});
                check("prog_rd", {15'h0000, prog_rd}, {15'h0000, n.rd});
                if (n.rd)
                    check("prog_addr", {4'h0, prog_addr}, {4'h0, n.pa});
                check("table_read_high_reg", {9'h000, table_read_high_reg}, {9'h000, n.th});
            end
        end
    end

    function automatic mase_req_t rnd_req(int k);
        mase_req_t r;
        logic [9:0] d;
        d = 10'($urandom);
        if (d[9:8] == 2'h0)
            d[7:0] = 8'h00;
        else if (d[9:8] == 2'h1)
            d[7:0] = 8'hFF;
        r.valid = 1'b1;
        r.op = (k <= 15) ? mase_op_t'(k) : MASE_OP_NONE;
        r.xop = (k > 15) ? mase_xop_t'(k - 15) : MASE_XOP_NONE;
        r.bit_sel = 3'($urandom);
        r.mem_addr = 8'($urandom);
        r.mem_data = d[7:0];
        r.literal = 8'($urandom);
        return r;
    endfunction : rnd_req

    task automatic issue(input mase_req_t r);
        mase_tb_note_t n;
        logic [7:0] m, b, d;
        logic [14:0] w;
        logic two;
        @(posedge sys_clk_in);
        req_in <= r;
        pc_in <= 12'($urandom);
        tp_in <= 8'($urandom);
        #1;
        m = r.mem_data;
        n = '{ncyc + 2, e_acc, e_fl, 1'b0, r.mem_addr, 8'h00, 1'b0, 1'b0,
              1'b0, 12'h000, e_th};
        two = 1'b0;
        if (r.xop != MASE_XOP_NONE) begin
            d = e_acc ^ ((r.xop == MASE_XOP_XOR_X) ? r.literal : m);
            n.fl.z = (d == 8'h00);
            if (r.xop == MASE_XOP_XOR_M) begin
                n.we = 1'b1;
                n.wd = d;
            end else
                n.acc = d;
        end else begin
            case (r.op)
                MASE_OP_FILL: {n.we, n.wd} = {1'b1, 8'hFF};
                MASE_OP_BITSET: {n.we, n.wd} = {1'b1, m | (8'h01 << r.bit_sel)};
                MASE_OP_INC_SKIP, MASE_OP_INC_SKIP_A: begin
                    d = m + 8'h01;
                    n.skip = (d == 8'h00);
                    if (r.op == MASE_OP_INC_SKIP)
                        {n.we, n.wd} = {1'b1, d};
                    else
                        n.acc = d;
                    two = 1'b1;
                end
                MASE_OP_SKIP_BIT_HIGH: {two, n.skip} = {1'b1, m[r.bit_sel]};
                MASE_OP_SKIP_BIT_LOW: {two, n.skip} = {1'b1, ~m[r.bit_sel]};
                MASE_OP_SKIP_ZERO: {two, n.skip} = {1'b1, m == 8'h00};
                MASE_OP_COPY_SKIP: begin
                    {two, n.skip, n.acc} = {1'b1, m == 8'h00, m};
                end
                MASE_OP_SUB_A, MASE_OP_SUB_M, MASE_OP_SUB_X: begin
                    b = (r.op == MASE_OP_SUB_X) ? r.literal : m;
                    d = e_acc - b;
                    n.fl.ov = (e_acc[7] != b[7]) && (d[7] != e_acc[7]);
                    n.fl.z = (d == 8'h00);
                    n.fl.ac = (e_acc[3:0] >= b[3:0]);
                    n.fl.c = (e_acc >= b);
                    if (r.op == MASE_OP_SUB_M)
                        {n.we, n.wd} = {1'b1, d};
                    else
                        n.acc = d;
                end
                MASE_OP_SWAP: {n.we, n.wd} = {1'b1, m[3:0], m[7:4]};
                MASE_OP_SWAP_A: n.acc = {m[3:0], m[7:4]};
                MASE_OP_TAB_CUR, MASE_OP_TAB_LAST: begin
                    n.rd = 1'b1;
                    n.pa = (r.op == MASE_OP_TAB_LAST) ? {4'hF, tp_in} :
                        {pc_in[11:8], tp_in};
                    two = 1'b1;
                end
                default: ;
            endcase
        end
        n.busy = two;
        e_acc = n.acc;
        e_fl = n.fl;
        notes.push_back(n);
        if (two) begin
            n.due++;
            {n.we, n.skip, n.busy} = 3'b000;
            if (n.rd) begin
                w = word(n.pa);
                {n.we, n.th, n.wd} = {1'b1, w};
                e_th = n.th;
            end
            n.rd = 1'b0;
            notes.push_back(n);
            // Request offered while busy must be ignored
            @(posedge sys_clk_in);
            req_in <= rnd_req(18);
        end
    endtask : issue

    initial begin : main
        mase_tb_note_t z;
        mase_req_t r;
        void'($urandom(32'h726b_503e));
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        z = '{ncyc + 1, 8'h00, '0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0,
              12'h000, 7'h00};
        notes.push_back(z);
        $display("reset test done");
        for (int k = 1; k <= 18; k++)
            issue(rnd_req(k));
        r = rnd_req(16);
        r.mem_data = e_acc;
        issue(r);
        r = rnd_req(6);
        r.mem_data = e_acc;
        issue(r);
        r = rnd_req(3);
        r.mem_data = 8'hFF;
        issue(r);
        $display("directed test done");
        for (int i = 0; i < 400; i++)
            issue(rnd_req($urandom_range(1, 18)));
        @(posedge sys_clk_in);
        req_in <= '0;
        repeat (4) @(posedge sys_clk_in);
        check("notes left", 16'(notes.size()), 16'h0000);
        $display("random test done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
